// File: bench/pixel_shader_vga_chk.sv
`timescale 1ns/10ps
`default_nettype none
module pixel_shader_vga_chk
  import shader_pkg::*;
#(parameter int unsigned PIXEL_DIVIDE = PIXEL_DIV) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        prog_mode,
  input wire spi_in_type  spi_pins,
  input wire logic        miso_out,
  input wire logic        miso_oe,
  input wire vga_out_type vga_out,
  input wire logic        line_marker,
  input wire logic        frame_marker
);
  localparam int MARK = PIXEL_DIVIDE;
  localparam int HS_GAP = 16 * PIXEL_DIVIDE;
  localparam int HS_LEN = 96 * PIXEL_DIVIDE;
  localparam int LINE_CYC = 800 * PIXEL_DIVIDE;
  logic [15:0] lcnt_r;
  logic        armed_r;
  logic        mark_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // cycles since the last line marker began; a full line is too long for a delay
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lcnt_r <= '0;
      armed_r <= 1'b0;
      mark_r <= 1'b0;
    end else begin
      mark_r <= line_marker;
      lcnt_r <= (line_marker && !mark_r) ? 16'h0000 : lcnt_r + 16'h0001;
      armed_r <= armed_r | (line_marker && !mark_r);
    end
  end
  AST_MISO_IDLE: assert property (!miso_oe && !miso_out)
    else $error("miso driven");
  AST_H_BLANK: assert property (!vga_out.hsync |-> vga_out.colour == '0)
    else $error("colour in hsync");
  AST_V_BLANK: assert property (!vga_out.vsync |-> vga_out.colour == '0)
    else $error("colour in vsync");
  AST_MARK_LEN: assert property ($rose(line_marker) |-> ##[MARK:MARK] $fell(line_marker))
    else $error("line marker length");
  AST_HS_GAP: assert property ($rose(line_marker) |-> ##[HS_GAP:HS_GAP] $fell(vga_out.hsync))
    else $error("front porch length");
  AST_HS_LEN: assert property ($fell(vga_out.hsync) |-> ##[HS_LEN:HS_LEN] $rose(vga_out.hsync))
    else $error("hsync width");
  AST_LINE_PERIOD: assert property (line_marker && !mark_r && armed_r |-> lcnt_r == 16'(LINE_CYC - 1))
    else $error("line period");
  AST_FRAME_MARK: assert property (frame_marker |-> vga_out.hsync && !line_marker && vga_out.colour == '0)
    else $error("frame marker place");
endmodule : pixel_shader_vga_chk
bind pixel_shader_vga pixel_shader_vga_chk #(.PIXEL_DIVIDE(PIXEL_DIVIDE)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .prog_mode(prog_mode), .spi_pins(spi_pins), .miso_out(miso_out),
  .miso_oe(miso_oe), .vga_out(vga_out), .line_marker(line_marker), .frame_marker(frame_marker));
`default_nettype wire

// File: bench/pixel_shader_vga_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module pixel_shader_vga_tb_top;
  import shader_pkg::*;
  localparam int PD = 2; // shorter pixel step keeps lines short
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        prog_mode = 1'b0;
  spi_in_type  spi_pins;
  vga_out_type vga_out;
  logic        miso_out;
  logic        miso_oe;
  logic        line_marker;
  logic        frame_marker;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0;
  // program bytes, instruction 0 first, then the colour it gives
  logic [85:0] progs [15] = '{
    {80'h6a008080808080808080, 6'h2a},
    {80'h80808080808080804104, 6'h1a},
    {80'h45c443d4018080808080, 6'h08},
    {80'h43c845e2008080808080, 6'h28},
    {80'h42c870f2008080808080, 6'h0c},
    {80'h4fa40180808080808080, 6'h30},
    {80'h4fc47cb4018080808080, 6'h33},
    {80'h47205100808080808080, 6'h11},
    {80'h47392151008080808080, 6'h07},
    {80'h47392d51008080808080, 6'h11},
    {80'h47245100808080808080, 6'h07},
    {80'h513c0080808080808080, 6'h3e},
    {80'h45300080808080808080, 6'h0a},
    {80'h1c008080808080808080, 6'h25},
    {80'h10008080808080808080, 6'h1d}};
  always #4 core_clk = ~core_clk; // clock before video is judged
  pixel_shader_vga #(.PIXEL_DIVIDE(PD)) dut (.core_clk(core_clk), .rst_n(rst_n), .prog_mode(prog_mode),
    .spi_pins(spi_pins), .miso_out(miso_out), .miso_oe(miso_oe), .vga_out(vga_out),
    .line_marker(line_marker), .frame_marker(frame_marker));
  spi_ctrl_model host (.pins(spi_pins));
  task automatic check(input string what, input logic [5:0] exp, input logic [5:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // colour at pixel 305 of the next line, i.e. the program run for cell 29
  task automatic sample_cell(input logic [5:0] exp);
    int n;
    for (n = 0; n < 2000 && line_marker !== 1'b1; n++) @(negedge core_clk);
    repeat ((160 + 305) * PD) @(negedge core_clk);
    check("cell colour", exp, vga_out.colour);
  endtask : sample_cell
  task automatic do_reset();
    @(posedge core_clk) rst_n <= 1'b0;
    repeat (2) @(negedge core_clk);
    check("sync idle", 6'h03, {4'h0, vga_out.hsync, vga_out.vsync});
    check("blank colour", 6'h00, vga_out.colour);
    check("markers", 6'h00, {4'h0, line_marker, frame_marker});
    @(posedge core_clk) rst_n <= 1'b1;
    sample_cell(6'h1d);
    $display("reset test done");
  endtask : do_reset
  task automatic run_programs();
    int k;
    int i;
    @(posedge core_clk) prog_mode <= 1'b0;
    repeat (4) @(posedge core_clk);
    host.send(8'he5);
    for (k = 0; k < 15; k++) begin
      @(posedge core_clk) prog_mode <= 1'b1;
      repeat (4) @(posedge core_clk);
      for (i = 9; i >= 0; i--) host.send(progs[k][i*8+6 +: 8]);
      sample_cell(progs[k][5:0]);
    end
    $display("program test done");
  endtask : run_programs
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // hang guard, about twice the expected run
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      bad_count++;
      $display("ERROR timeout expected end seen hang");
      conclude();
    end
  end
  initial begin
    do_reset();
    run_programs();
    do_reset();
    conclude();
  end
endmodule : pixel_shader_vga_tb_top
`default_nettype wire

// File: bench/spi_ctrl_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_ctrl_model
  import shader_pkg::*;
(
  output var spi_in_type pins
);
  // deselected with the clock parked low outside frames
  initial pins = '{cs_n: 1'b1, mosi: 1'b0, sck: 1'b0};
  // one framed byte, mode 0, msb first
  task automatic send(input logic [7:0] b);
    int i;
    #3 pins.cs_n = 1'b0;
    for (i = 7; i >= 0; i--) begin
      pins.mosi = b[i];
      #40 pins.sck = 1'b1;
      #40 pins.sck = 1'b0;
    end
    #40 pins.cs_n = 1'b1;
    pins.mosi = ~pins.mosi; // released line never repeats a stale bit
  endtask : send
endmodule : spi_ctrl_model
`default_nettype wire

// File: hw/pixel_shader_vga.sv
// What this block does
// - run all ten stored instructions for every cell, one per pixel, no framebuffer
// - 640x480 60 Hz video, each shaded cell ten by ten pixels
// - four six-bit working registers, register zero as implied operand
// - time steps at 7.5 Hz and bounces between its limits
// - colour channels written separately; unwritten ones keep last value
// - sixteen quarter sine samples mirrored into 32-entry half wave
// - sine indexes table with low five bits of register zero
// - whole colour copies register; channel ops copy its low two bits
// - input ops load x, y, time or user value
// - conditionals compare with register zero and skip next if false
// - add two registers into the first
// - double and halve a register in place
// - clear writes zero; load immediate writes the carried constant
// - and, or, xor into first; invert writes complement of second
// - copy second register into first
// - shift first register left or right by second register
// - spi bytes set user value from low six bits when mode low
// - spi bytes shift into program memory when mode high
// - reset loads a built-in default program
`timescale 1ns/10ps
`default_nettype none

module pixel_shader_vga
  import shader_pkg::*;
#(
  parameter int unsigned PIXEL_DIVIDE = PIXEL_DIV
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        prog_mode,
  input  wire spi_in_type  spi_pins,
  output logic             miso_out,
  output logic             miso_oe,
  output vga_out_type      vga_out,
  output logic             line_marker,
  output logic             frame_marker
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic        mode_meta_r;
  logic        mode_sync_r;
  logic [2:0]  div_r;
  logic [2:0]  div_nxt;
  logic        pix_tick;
  logic [9:0]  hcnt_r;
  logic [9:0]  hcnt_nxt;
  logic [9:0]  vcnt_r;
  logic [9:0]  vcnt_nxt;
  logic [3:0]  hsub_r;
  logic [3:0]  hsub_nxt;
  logic [3:0]  vsub_r;
  logic [3:0]  vsub_nxt;
  logic [5:0]  xcell_r;
  logic [5:0]  xcell_nxt;
  logic [5:0]  ycell_r;
  logic [5:0]  ycell_nxt;
  logic [2:0]  frame_cnt_r;
  logic [2:0]  frame_cnt_nxt;
  logic [5:0]  time_r;
  logic [5:0]  time_nxt;
  logic        time_up_r;
  logic        time_up_nxt;
  vga_out_type vga_r;
  vga_out_type vga_nxt;
  logic        line_r;
  logic        line_nxt;
  logic        frame_r;
  logic        frame_nxt;
  logic [5:0]  regs_r [4];
  logic [5:0]  regs_nxt [4];
  logic        take_r;
  logic        take_nxt;
  colour_type  colour_r;
  colour_type  colour_nxt;
  colour_type  shown_r;
  colour_type  shown_nxt;
  logic [7:0]  prog_r [PROG_LEN];
  logic [7:0]  prog_nxt [PROG_LEN];
  logic [5:0]  user_r;
  logic [5:0]  user_nxt;
  logic        byte_valid;
  logic [7:0]  byte_data;
  logic [5:0]  sine_value;
  logic [7:0]  instr;
  logic [5:0]  ra_val;
  logic [5:0]  rb_val;
  logic [5:0]  r0_val;
  logic        frame_end;
  logic        visible;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  shader_spi_rx u_spi_rx (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .spi_pins   (spi_pins),
    .byte_valid (byte_valid),
    .byte_data  (byte_data)
  );

  shader_sine_lut u_sine (
    .index (r0_val[4:0]),
    .value (sine_value)
  );

  // mode is a pin, so it is synchronised before use
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_meta_r <= 1'b0;
      mode_sync_r <= 1'b0;
    end else begin
      mode_meta_r <= prog_mode;
      mode_sync_r <= mode_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // video timing
  // ----------------------------------------------------------------
  assign pix_tick  = (div_r == 3'(PIXEL_DIVIDE - 1));
  assign frame_end = pix_tick && (hcnt_r == H_LAST) && (vcnt_r == V_LAST);
  assign visible   = (hcnt_r < H_VIS_END) && (vcnt_r < V_VIS_END);

  // pixel rate is derived from the core clock by a divider, not a second domain
  // raster and cell counters
  always_comb begin
    div_nxt   = pix_tick ? 3'h0 : div_r + 3'h1;
    hcnt_nxt  = hcnt_r;
    vcnt_nxt  = vcnt_r;
    hsub_nxt  = hsub_r;
    vsub_nxt  = vsub_r;
    xcell_nxt = xcell_r;
    ycell_nxt = ycell_r;
    if (pix_tick) begin
      hsub_nxt = (hsub_r == CELL_LAST) ? 4'h0 : hsub_r + 4'h1;
      if (hsub_r == CELL_LAST) begin
        xcell_nxt = xcell_r + 6'h01;
      end
      if (hcnt_r == H_LAST) begin
        hcnt_nxt  = 10'h000;
        hsub_nxt  = 4'h0;
        xcell_nxt = 6'h00;
        vsub_nxt  = (vsub_r == CELL_LAST) ? 4'h0 : vsub_r + 4'h1;
        if (vsub_r == CELL_LAST) begin
          ycell_nxt = ycell_r + 6'h01;
        end
        if (vcnt_r == V_LAST) begin
          vcnt_nxt  = 10'h000;
          vsub_nxt  = 4'h0;
          ycell_nxt = 6'h00;
        end else begin
          vcnt_nxt = vcnt_r + 10'h001;
        end
      end else begin
        hcnt_nxt = hcnt_r + 10'h001;
      end
    end
  end

  // sync pulses are active low; colour is blanked outside the visible area
  // sync, blanking, markers
  always_comb begin
    vga_nxt.hsync  = !((hcnt_r >= H_SYNC_START) && (hcnt_r < H_SYNC_END));
    vga_nxt.vsync  = !((vcnt_r >= V_SYNC_START) && (vcnt_r < V_SYNC_END));
    vga_nxt.colour = visible ? shown_r : COLOUR_RESET;
    line_nxt       = (hcnt_r == H_VIS_END);
    frame_nxt      = (vcnt_r == V_VIS_END) && (hcnt_r == 10'h000);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r   <= 3'h0;
      hcnt_r  <= 10'h000;
      vcnt_r  <= 10'h000;
      hsub_r  <= 4'h0;
      vsub_r  <= 4'h0;
      xcell_r <= 6'h00;
      ycell_r <= 6'h00;
      vga_r   <= '{hsync: 1'b1, vsync: 1'b1, colour: COLOUR_RESET};
      line_r  <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      hcnt_r  <= hcnt_nxt;
      vcnt_r  <= vcnt_nxt;
      hsub_r  <= hsub_nxt;
      vsub_r  <= vsub_nxt;
      xcell_r <= xcell_nxt;
      ycell_r <= ycell_nxt;
      vga_r   <= vga_nxt;
      line_r  <= line_nxt;
      frame_r <= frame_nxt;
    end
  end

  // ----------------------------------------------------------------
  // bouncing time value
  // ----------------------------------------------------------------
  // 7.5 Hz bounce
  always_comb begin
    frame_cnt_nxt = frame_cnt_r;
    time_nxt      = time_r;
    time_up_nxt   = time_up_r;
    if (frame_end) begin
      frame_cnt_nxt = frame_cnt_r + 3'h1;
      if (frame_cnt_r == FRAMES_PER_TICK_LAST) begin
        if (time_up_r) begin
          if (time_r == 6'h3f) begin
            time_up_nxt = 1'b0;
            time_nxt    = 6'h3e;
          end else begin
            time_nxt = time_r + 6'h01;
          end
        end else begin
          if (time_r == 6'h00) begin
            time_up_nxt = 1'b1;
            time_nxt    = 6'h01;
          end else begin
            time_nxt = time_r - 6'h01;
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_r <= 3'h0;
      time_r      <= 6'h00;
      time_up_r   <= 1'b1;
    end else begin
      frame_cnt_r <= frame_cnt_nxt;
      time_r      <= time_nxt;
      time_up_r   <= time_up_nxt;
    end
  end

  // ----------------------------------------------------------------
  // shader core: one instruction per video pixel of the cell
  // ----------------------------------------------------------------
  assign instr  = prog_r[hsub_r];
  assign ra_val = regs_r[instr[3:2]];
  assign rb_val = regs_r[instr[1:0]];
  assign r0_val = regs_r[WORK_REG_ZERO];

  always_comb begin
    single_op_type sop;
    logic [1:0]    dst;
    sop        = single_op_type'(instr[5:2]);
    dst        = instr[1:0];
    regs_nxt   = regs_r;
    take_nxt   = take_r;
    colour_nxt = colour_r;
    shown_nxt  = shown_r;
    if (pix_tick) begin
      // previous cell's result is shown while this cell is shaded
      if (hsub_r == 4'h0) begin
        shown_nxt = colour_r;
      end
      take_nxt = 1'b1;
      // a skipped instruction only re-arms the condition
      if (take_r) begin
        unique case (instr[7:6])
          CLASS_SINGLE: begin
            unique case (sop)
              set_colour_op: colour_nxt = colour_type'(regs_r[dst]);
              set_red_op:    colour_nxt.red   = regs_r[dst][1:0];
              set_green_op:  colour_nxt.green = regs_r[dst][1:0];
              set_blue_op:   colour_nxt.blue  = regs_r[dst][1:0];
              load_xpos_op:  regs_nxt[dst] = xcell_r;
              load_ypos_op:  regs_nxt[dst] = ycell_r;
              load_time_op:  regs_nxt[dst] = time_r;
              load_user_op:  regs_nxt[dst] = user_r;
              skip_unless_equal:         take_nxt = (regs_r[dst] == r0_val);
              skip_unless_unequal:       take_nxt = (regs_r[dst] != r0_val);
              skip_unless_greater_equal: take_nxt = (regs_r[dst] >= r0_val);
              skip_unless_less:          take_nxt = (regs_r[dst] < r0_val);
              double_op:     regs_nxt[dst] = {regs_r[dst][4:0], 1'b0};
              halve_op:      regs_nxt[dst] = {1'b0, regs_r[dst][5:1]};
              clear_op:      regs_nxt[dst] = 6'h00;
              sine_op:       regs_nxt[dst] = sine_value;
            endcase
          end
          CLASS_LDI: regs_nxt[WORK_REG_ZERO] = instr[5:0];
          CLASS_BOOL: begin
            unique case (bool_op_type'(instr[5:4]))
              and_op: regs_nxt[instr[3:2]] = ra_val & rb_val;
              or_op:  regs_nxt[instr[3:2]] = ra_val | rb_val;
              not_op: regs_nxt[instr[3:2]] = ~rb_val;
              xor_op: regs_nxt[instr[3:2]] = ra_val ^ rb_val;
            endcase
          end
          CLASS_MOVE: begin
            unique case (move_op_type'(instr[5:4]))
              copy_op:        regs_nxt[instr[3:2]] = rb_val;
              add_op:         regs_nxt[instr[3:2]] = 6'(ra_val + rb_val);
              shift_left_op:  regs_nxt[instr[3:2]] = ra_val << rb_val;
              shift_right_op: regs_nxt[instr[3:2]] = ra_val >> rb_val;
            endcase
          end
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 4; i++) begin
        regs_r[i] <= 6'h00;
      end
      take_r   <= 1'b1;
      colour_r <= COLOUR_RESET;
      shown_r  <= COLOUR_RESET;
    end else begin
      regs_r   <= regs_nxt;
      take_r   <= take_nxt;
      colour_r <= colour_nxt;
      shown_r  <= shown_nxt;
    end
  end

  // ----------------------------------------------------------------
  // program memory and user value
  // ----------------------------------------------------------------
  // a new byte enters at the last slot; ten bytes replace the program.
  // loading while the raster runs may show a mixed program briefly
  always_comb begin
    prog_nxt = prog_r;
    user_nxt = user_r;
    if (byte_valid) begin
      if (mode_sync_r) begin
        for (int i = 0; i < PROG_LEN - 1; i++) begin
          prog_nxt[i] = prog_r[i + 1];
        end
        prog_nxt[PROG_LEN - 1] = byte_data;
      end else begin
        user_nxt = byte_data[5:0];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prog_r <= DEFAULT_PROG;
      user_r <= 6'h00;
    end else begin
      prog_r <= prog_nxt;
      user_r <= user_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // the receiver is write only, so the return line is held low
  assign miso_out     = 1'b0;
  assign miso_oe      = 1'b0;
  assign vga_out      = vga_r;
  assign line_marker  = line_r;
  assign frame_marker = frame_r;

endmodule : pixel_shader_vga

`default_nettype wire

// File: hw/shader_pkg.sv
package shader_pkg;

  // ----------------------------------------------------------------
  // clocking and video timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ   = 125_000_000;
  localparam int unsigned PIXEL_RATE_HZ = 25_175_000;
  // least pixel period, rounded up to whole core cycles
  localparam int unsigned PIXEL_DIV     = (CORE_CLK_HZ + PIXEL_RATE_HZ - 1) / PIXEL_RATE_HZ;

  localparam int unsigned H_VISIBLE = 640;
  localparam int unsigned H_FRONT   = 16;
  localparam int unsigned H_SYNC    = 96;
  localparam int unsigned H_BACK    = 48;
  localparam int unsigned H_TOTAL   = H_VISIBLE + H_FRONT + H_SYNC + H_BACK;
  localparam int unsigned V_VISIBLE = 480;
  localparam int unsigned V_FRONT   = 10;
  localparam int unsigned V_SYNC    = 2;
  localparam int unsigned V_BACK    = 33;
  localparam int unsigned V_TOTAL   = V_VISIBLE + V_FRONT + V_SYNC + V_BACK;

  localparam logic [9:0] H_LAST       = 10'(H_TOTAL - 1);
  localparam logic [9:0] V_LAST       = 10'(V_TOTAL - 1);
  localparam logic [9:0] H_VIS_END    = 10'(H_VISIBLE);
  localparam logic [9:0] V_VIS_END    = 10'(V_VISIBLE);
  localparam logic [9:0] H_SYNC_START = 10'(H_VISIBLE + H_FRONT);
  localparam logic [9:0] H_SYNC_END   = 10'(H_VISIBLE + H_FRONT + H_SYNC);
  localparam logic [9:0] V_SYNC_START = 10'(V_VISIBLE + V_FRONT);
  localparam logic [9:0] V_SYNC_END   = 10'(V_VISIBLE + V_FRONT + V_SYNC);

  // cell size in video pixels, equal to program length
  localparam int unsigned PROG_LEN   = 10;
  localparam logic [3:0]  CELL_LAST  = 4'(PROG_LEN - 1);
  // time steps when the frame count reaches this, once per 8 frames (60 Hz / 8 = 7.5 Hz)
  localparam logic [2:0]  FRAMES_PER_TICK_LAST = 3'h7;

  // ----------------------------------------------------------------
  // instruction encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] CLASS_SINGLE = 2'h0;  // {00, op4, ra}
  localparam logic [1:0] CLASS_LDI    = 2'h1;  // {01, imm6} into reg 0
  localparam logic [1:0] CLASS_BOOL   = 2'h2;  // {10, op2, ra, rb}
  localparam logic [1:0] CLASS_MOVE   = 2'h3;  // {11, op2, ra, rb}

  typedef enum logic [3:0] {
    set_colour_op             = 4'h0,
    set_red_op                = 4'h1,
    set_green_op              = 4'h2,
    set_blue_op               = 4'h3,
    load_xpos_op              = 4'h4,
    load_ypos_op              = 4'h5,
    load_time_op              = 4'h6,
    load_user_op              = 4'h7,
    skip_unless_equal         = 4'h8,
    skip_unless_unequal       = 4'h9,
    skip_unless_greater_equal = 4'ha,
    skip_unless_less          = 4'hb,
    double_op                 = 4'hc,
    halve_op                  = 4'hd,
    clear_op                  = 4'he,
    sine_op                   = 4'hf
  } single_op_type;

  typedef enum logic [1:0] {
    and_op = 2'h0,
    or_op  = 2'h1,
    not_op = 2'h2,
    xor_op = 2'h3
  } bool_op_type;

  typedef enum logic [1:0] {
    copy_op        = 2'h0,
    add_op         = 2'h1,
    shift_left_op  = 2'h2,
    shift_right_op = 2'h3
  } move_op_type;

  localparam logic [1:0] WORK_REG_ZERO = 2'h0;

  // built-in program: rainbow coloured sine wave
  localparam logic [7:0] DEFAULT_PROG [PROG_LEN] = '{
    8'h3b,  // clear r3
    8'h10,  // load x into r0
    8'h1d,  // load user into r1
    8'hd1,  // r0 = r0 + r1
    8'h00,  // colour = r0
    8'h3c,  // r0 = sine(r0)
    8'h34,  // halve r0
    8'h15,  // load y into r1
    8'h29,  // skip next unless r1 >= r0
    8'h03   // colour = r3
  };

  // quarter sine wave, 16 six-bit samples
  localparam logic [5:0] SINE_QUARTER [16] = '{
    6'h00, 6'h06, 6'h0c, 6'h12, 6'h18, 6'h1e, 6'h23, 6'h28,
    6'h2d, 6'h31, 6'h34, 6'h37, 6'h3a, 6'h3c, 6'h3e, 6'h3f
  };

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] red;
    logic [1:0] green;
    logic [1:0] blue;
  } colour_type;

  typedef struct packed {
    logic       hsync;
    logic       vsync;
    colour_type colour;
  } vga_out_type;

  typedef struct packed {
    logic cs_n;
    logic mosi;
    logic sck;
  } spi_in_type;

  localparam colour_type COLOUR_RESET = '{red: 2'h0, green: 2'h0, blue: 2'h0};

endpackage : shader_pkg

// File: hw/shader_sine_lut.sv
`timescale 1ns/10ps
`default_nettype none

module shader_sine_lut
  import shader_pkg::*;
(
  input  wire logic [4:0] index,
  output logic      [5:0] value
);

  // ----------------------------------------------------------------
  // mirrored half wave
  // ----------------------------------------------------------------
  // upper half of the index walks the quarter table backwards
  // mirrored table access
  always_comb begin
    if (index[4]) begin
      value = SINE_QUARTER[~index[3:0]];
    end else begin
      value = SINE_QUARTER[index[3:0]];
    end
  end

endmodule : shader_sine_lut

`default_nettype wire

// File: hw/shader_spi_rx.sv
`timescale 1ns/10ps
`default_nettype none

module shader_spi_rx
  import shader_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire spi_in_type spi_pins,
  output logic            byte_valid,
  output logic      [7:0] byte_data
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  spi_in_type meta_r;
  spi_in_type sync_r;
  logic       sck_prev_r;
  logic [2:0] bit_cnt_r;
  logic [2:0] bit_cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic       valid_r;
  logic       valid_nxt;
  logic [7:0] data_r;
  logic [7:0] data_nxt;
  logic       sck_rise;

  // only the second stage feeds edge detection and data capture
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r     <= '{cs_n: 1'b1, mosi: 1'b0, sck: 1'b0};
      sync_r     <= '{cs_n: 1'b1, mosi: 1'b0, sck: 1'b0};
      sck_prev_r <= 1'b0;
    end else begin
      meta_r     <= spi_pins;
      sync_r     <= meta_r;
      sck_prev_r <= sync_r.sck;
    end
  end

  assign sck_rise = sync_r.sck & ~sck_prev_r;

  // ----------------------------------------------------------------
  // mode 0 receiver, msb first
  // ----------------------------------------------------------------
  // deselect drops a partial byte so framing restarts cleanly
  // spi mode framing
  always_comb begin
    bit_cnt_nxt = bit_cnt_r;
    shift_nxt   = shift_r;
    valid_nxt   = 1'b0;
    data_nxt    = data_r;
    if (sync_r.cs_n) begin
      bit_cnt_nxt = 3'h0;
    end else if (sck_rise) begin
      shift_nxt   = {shift_r[6:0], sync_r.mosi};
      bit_cnt_nxt = bit_cnt_r + 3'h1;
      if (bit_cnt_r == 3'h7) begin
        valid_nxt = 1'b1;
        data_nxt  = {shift_r[6:0], sync_r.mosi};
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_r <= 3'h0;
      shift_r   <= 8'h00;
      valid_r   <= 1'b0;
      data_r    <= 8'h00;
    end else begin
      bit_cnt_r <= bit_cnt_nxt;
      shift_r   <= shift_nxt;
      valid_r   <= valid_nxt;
      data_r    <= data_nxt;
    end
  end

  assign byte_valid = valid_r;
  assign byte_data  = data_r;

endmodule : shader_spi_rx

`default_nettype wire
